// ### rtl/tape_gate_pkg.sv
// Operation
// - the first reader is selected only for an input transfer to unit 04 with the fill switch off.
// - the second reader is selected by the same decode but for unit 05.
// - the pinch roller runs while a reader is selected or the feed switch is on, and the brake is its inverse.
// - the sprocket signal is passed on as the gated feed hole only while a reader is selected.
// - each data channel is gated by the select, bit one from channel 6 through bit six from channel 1, parity from channel 7.
// - the input character clock comes from the gated feed hole and only while a reader is addressed.
// - before the transfer flag is set a clock needs a punched channel; afterwards every feed hole clocks.
// - leading blank tape gives no clocks while blank tape after the flag is set is clocked.
// - in input the transfer flag sets when the clock detector is set and the upper count bit is clear.
// - the character is checked for odd parity over six data bits and the parity bit.
// - the skip parity option stops the parity check from setting the error flag.
// - the gated data bits feed the six character inputs and the gated parity the parity flop input.
// - the direction flag is true for output and false for input, and the decode needs false.
// - the five bit unit field names the unit and feeds the reader decode.
`default_nettype none
package tape_gate_pkg;
  localparam logic [4:0]  UNIT_READER1   = 5'h04;
  localparam logic [4:0]  UNIT_READER2   = 5'h05;
  localparam logic [11:0] ADDR_CTRL      = 12'h000;
  localparam logic [11:0] ADDR_STATUS    = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STAT  = 12'h008;
  localparam logic [11:0] ADDR_IRQ_MASK  = 12'h00C;
  localparam int          CTRL_UNIT_LSB  = 0;
  localparam int          CTRL_DIR_BIT   = 5;
  localparam int          CTRL_SKIPP_BIT = 6;
  localparam int          CTRL_CLEAR_BIT = 7;
  localparam logic [1:0]  AXI_OKAY       = 2'h0;
  localparam logic [1:0]  AXI_SLVERR     = 2'h2;
  localparam int          IRQ_CLK        = 0;
  localparam int          IRQ_ERR        = 1;

  typedef struct packed {
    logic       parity;
    logic [5:0] data;
  } tape_char_t;
endpackage : tape_gate_pkg
`default_nettype wire

// ### rtl/paper_tape_reader_input_gating.sv
`timescale 1ns/1ps
`default_nettype none
module paper_tape_reader_input_gating
  import tape_gate_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [11:0] s_axi_awaddr_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  output logic [1:0]       s_axi_bresp_out,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  input  wire logic [11:0] s_axi_araddr_in,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  input  wire logic        second_reader_in,
  input  wire logic        fill_switch_in,
  input  wire logic        tape_feed_switch_in,
  input  wire logic        sprocket_amp_in,
  input  wire logic [7:1]  channel_amp_in,
  output logic             pinch_roller_out,
  output logic             brake_drive_out,
  output logic             gated_feed_hole_out,
  output logic [5:0]       char_buffer_inputs_out,
  output logic             odd_parity_flop_out,
  output logic             input_clock_out,
  output logic             transfer_running_out,
  output logic             parity_error_out,
  output logic             irq_out
);
  // pin synchronisers: stage one feeds only stage two
  logic [9:0] sync1_ff;
  logic [9:0] sync2_ff;
  always_ff @(posedge clk_in)
  begin
    sync1_ff <= {fill_switch_in, tape_feed_switch_in, sprocket_amp_in, channel_amp_in};
    sync2_ff <= sync1_ff;
  end
  wire       fill_switch = sync2_ff[9];
  wire       feed_switch = sync2_ff[8];
  wire       sprocket    = sync2_ff[7];
  wire [7:1] chan        = sync2_ff[6:0];

  // unit address / direction register and options
  logic [4:0] unit_select_field_ff;
  logic       output_direction_ff;
  logic       skip_parity_check_ff;
  logic       transfer_running_ff;
  logic       clock_detect_flop_ff;
  logic [1:0] char_count_ff;
  logic       error_ff;
  logic [1:0] irq_stat_ff;
  logic [1:0] irq_mask_ff;

  wire [4:0] reader_code = second_reader_in ? UNIT_READER2 : UNIT_READER1;
  wire tape_unit_selected = !output_direction_ff && (unit_select_field_ff == reader_code)
                            && !fill_switch;

  wire sprocket_gated = sprocket & tape_unit_selected;
  tape_char_t gated_char;
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_bits
      assign gated_char.data[gi] = chan[6 - gi] & tape_unit_selected;
    end
  endgenerate
  assign gated_char.parity = chan[7] & tape_unit_selected;

  wire any_punched = (|gated_char.data) | gated_char.parity;
  wire clock_level = (any_punched | transfer_running_ff) & sprocket_gated & tape_unit_selected;
  logic clock_level_ff;
  wire  clock_rise = clock_level & !clock_level_ff;
  wire  odd_ok     = ^{gated_char.data, gated_char.parity};
  wire  err_event  = clock_rise & !odd_ok & !skip_parity_check_ff;

  // bus decode: each channel is taken on its own handshake, the write acts once both halves are in
  logic        aw_got_ff;
  logic        w_got_ff;
  logic [11:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  wire aw_take    = s_axi_awvalid_in && s_axi_awready_out;
  wire w_take     = s_axi_wvalid_in && s_axi_wready_out;
  wire rd_take    = s_axi_arvalid_in && s_axi_arready_out;
  wire do_write   = aw_got_ff && w_got_ff && !s_axi_bvalid_out;
  wire b_done     = s_axi_bvalid_out && s_axi_bready_in;
  wire r_done     = s_axi_rvalid_out && s_axi_rready_in;
  wire nxt_aw_got = !do_write && (aw_got_ff || aw_take);
  wire nxt_w_got  = !do_write && (w_got_ff || w_take);
  wire nxt_rvalid = rd_take || (s_axi_rvalid_out && !r_done);
  wire wr_ctrl  = do_write && awaddr_ff == ADDR_CTRL && wstrb_ff[0];
  wire wr_stat  = do_write && awaddr_ff == ADDR_IRQ_STAT && wstrb_ff[0];
  wire wr_mask  = do_write && awaddr_ff == ADDR_IRQ_MASK && wstrb_ff[0];
  wire wr_hit   = awaddr_ff == ADDR_CTRL || awaddr_ff == ADDR_STATUS ||
                  awaddr_ff == ADDR_IRQ_STAT || awaddr_ff == ADDR_IRQ_MASK;
  wire buffer_clear = wr_ctrl && wdata_ff[CTRL_CLEAR_BIT];
  wire rd_hit = s_axi_araddr_in == ADDR_CTRL || s_axi_araddr_in == ADDR_STATUS ||
                s_axi_araddr_in == ADDR_IRQ_STAT || s_axi_araddr_in == ADDR_IRQ_MASK;
  wire [31:0] rd_data =
    (s_axi_araddr_in == ADDR_CTRL)     ? {25'h0, skip_parity_check_ff, output_direction_ff, unit_select_field_ff} :
    (s_axi_araddr_in == ADDR_STATUS)   ? {27'h0, error_ff, char_count_ff, clock_detect_flop_ff, transfer_running_ff} :
    (s_axi_araddr_in == ADDR_IRQ_STAT) ? {30'h0, irq_stat_ff} :
    (s_axi_araddr_in == ADDR_IRQ_MASK) ? {30'h0, irq_mask_ff} : 32'h0;
  wire [1:0] irq_events = {err_event, clock_rise};
  wire [1:0] nxt_irq_stat = (irq_stat_ff & ~(wr_stat ? wdata_ff[1:0] : 2'h0)) | irq_events;

  // address and data stay held until the register write has used them
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
    end
    else
    begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff  <= nxt_w_got;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      awaddr_ff <= 12'h000;
    else if (aw_take)
      awaddr_ff <= s_axi_awaddr_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
    end
    else if (w_take)
    begin
      wdata_ff <= s_axi_wdata_in;
      wstrb_ff <= s_axi_wstrb_in;
    end
  end

  // readies are registered from the next holding state, so no output is combinational
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_arready_out <= 1'b0;
    end
    else
    begin
      s_axi_awready_out <= !nxt_aw_got;
      s_axi_wready_out  <= !nxt_w_got;
      s_axi_arready_out <= !nxt_rvalid;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= AXI_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= wr_hit ? AXI_OKAY : AXI_SLVERR;
    end
    else if (b_done)
      s_axi_bvalid_out <= 1'b0;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h0;
      s_axi_rresp_out  <= AXI_OKAY;
    end
    else
    begin
      s_axi_rvalid_out <= nxt_rvalid;
      if (rd_take)
      begin
        s_axi_rdata_out <= rd_data;
        s_axi_rresp_out <= rd_hit ? AXI_OKAY : AXI_SLVERR;
      end
    end
  end

  // buffer state: a clear drops the unit, so the gated feed hole, data, parity and clock outputs go inactive
  always_ff @(posedge clk_in)
  begin
    if (rst_in || buffer_clear)
    begin
      unit_select_field_ff <= 5'h00;
      output_direction_ff  <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      unit_select_field_ff <= wdata_ff[CTRL_UNIT_LSB +: 5];
      output_direction_ff  <= wdata_ff[CTRL_DIR_BIT];
    end
  end

  // skip parity takes the written value even on a clear, so one write clears and arms it
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      skip_parity_check_ff <= 1'b0;
    else if (wr_ctrl)
      skip_parity_check_ff <= wdata_ff[CTRL_SKIPP_BIT];
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in || buffer_clear)
    begin
      clock_level_ff       <= 1'b0;
      clock_detect_flop_ff <= 1'b0;
      char_count_ff        <= 2'h0;
    end
    else
    begin
      clock_level_ff <= clock_level;
      if (clock_rise)
      begin
        clock_detect_flop_ff <= 1'b1;
        char_count_ff        <= char_count_ff + 2'h1;
      end
    end
  end

  // detector set with upper count bit clear starts the transfer
  wire start_transfer = !output_direction_ff && clock_detect_flop_ff && !char_count_ff[1];
  always_ff @(posedge clk_in)
  begin
    if (rst_in || buffer_clear)
      transfer_running_ff <= 1'b0;
    else if (start_transfer)
      transfer_running_ff <= 1'b1;
  end

  // an error in the cycle of a clear survives it, so no bad character is lost
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      error_ff <= 1'b0;
    else if (err_event)
      error_ff <= 1'b1;
    else if (buffer_clear)
      error_ff <= 1'b0;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      irq_stat_ff <= 2'h0;
      irq_mask_ff <= 2'h0;
      irq_out     <= 1'b0;
    end
    else
    begin
      irq_stat_ff <= nxt_irq_stat;
      if (wr_mask)
        irq_mask_ff <= wdata_ff[1:0];
      irq_out <= |(nxt_irq_stat & (wr_mask ? wdata_ff[1:0] : irq_mask_ff));
    end
  end

  // registered pin drivers
  always_ff @(posedge clk_in)
  begin
    if (rst_in || buffer_clear)
    begin
      pinch_roller_out       <= 1'b0;
      brake_drive_out        <= 1'b1;
      gated_feed_hole_out    <= 1'b0;
      char_buffer_inputs_out <= 6'h00;
      odd_parity_flop_out    <= 1'b0;
      input_clock_out        <= 1'b0;
      transfer_running_out   <= 1'b0;
      parity_error_out       <= 1'b0;
    end
    else
    begin
      pinch_roller_out       <= tape_unit_selected | feed_switch;
      brake_drive_out        <= !(tape_unit_selected | feed_switch);
      gated_feed_hole_out    <= sprocket_gated;
      char_buffer_inputs_out <= gated_char.data;
      odd_parity_flop_out    <= gated_char.parity;
      input_clock_out        <= clock_level;
      transfer_running_out   <= transfer_running_ff;
      parity_error_out       <= error_ff | err_event;
    end
  end
endmodule // paper_tape_reader_input_gating
`default_nettype wire

// ### tb/tape_reader_model.sv
`timescale 1ns/1ps
`default_nettype none
module tape_reader_model (
  input  wire logic       frame_in,
  input  wire logic [7:1] holes_in,
  output logic            sprocket_out,
  output logic [7:1]      channel_out
);
  localparam time PERIOD = 125ns;
  // sprocket pulses only inside a frame, centred on the data holes
  initial
  begin
    sprocket_out = 1'b0;
    channel_out = 7'h00;
    forever
    begin
      @(posedge frame_in);
      channel_out = holes_in;
      #(PERIOD / 4) sprocket_out = 1'b1;
      #(PERIOD / 2) sprocket_out = 1'b0;
      // between frames the channels carry the inverse of the last pattern
      #(PERIOD / 4) channel_out = ~holes_in;
    end
  end
endmodule // tape_reader_model
`default_nettype wire

// ### tb/paper_tape_reader_input_gating_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tape_gate_checker (
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic       fill_switch_in,
  input wire logic       tape_feed_switch_in,
  input wire logic       pinch_roller_out,
  input wire logic       brake_drive_out,
  input wire logic       gated_feed_hole_out,
  input wire logic [5:0] char_buffer_inputs_out,
  input wire logic       odd_parity_flop_out,
  input wire logic       input_clock_out,
  input wire logic       transfer_running_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  wire logic punched;
  assign punched = |char_buffer_inputs_out || odd_parity_flop_out;
  brake_inverse_a: assert property (brake_drive_out == !pinch_roller_out) else $error("brake not inverse");
  feed_switch_a: assert property (tape_feed_switch_in [*5] |-> pinch_roller_out) else $error("feed no pinch");
  feed_gate_a: assert property (gated_feed_hole_out |-> pinch_roller_out) else $error("feed hole unselected");
  data_gate_a: assert property (punched |-> pinch_roller_out) else $error("data unselected");
  clock_source_a: assert property (input_clock_out |-> gated_feed_hole_out || $past(gated_feed_hole_out))
    else $error("clock without feed hole");
  leader_skip_a: assert property (input_clock_out && !transfer_running_out |-> punched || $past(punched))
    else $error("blank leader clocked");
  fill_block_a: assert property (fill_switch_in [*5] |-> !gated_feed_hole_out && !punched)
    else $error("fill did not block");
  flag_cause_a: assert property ($rose(transfer_running_out) |-> $past(input_clock_out) || $past(input_clock_out, 2))
    else $error("flag without clock");
endmodule // tape_gate_checker
bind paper_tape_reader_input_gating tape_gate_checker i_chk (.*);
`default_nettype wire

// ### tb/paper_tape_reader_input_gating_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module paper_tape_reader_input_gating_tb import tape_gate_pkg::*;;
  logic clk_in = 1'b0, rst_in = 1'b1, s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
  logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0, second_reader_in = 1'b0, fill_switch_in = 1'b0;
  logic tape_feed_switch_in = 1'b0, go = 1'b0, run_e, err_e, skip_e, sel_e;
  logic [11:0] s_axi_awaddr_in = 12'h000, s_axi_araddr_in = 12'h000;
  logic [31:0] s_axi_wdata_in = 32'h00000000, rdata_q;
  logic [3:0]  s_axi_wstrb_in = 4'hF;
  logic [1:0]  rresp_q;
  logic [7:1]  holes = 7'h00;
  wire logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  wire logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  wire logic [31:0] s_axi_rdata_out;
  wire logic [5:0] char_buffer_inputs_out;
  wire logic sprocket_amp_in, pinch_roller_out, brake_drive_out, gated_feed_hole_out, odd_parity_flop_out;
  wire logic input_clock_out, transfer_running_out, parity_error_out, irq_out;
  wire logic [7:1] channel_amp_in;
  integer seed = 32'h5f295dcf;
  int checks = 0, failures = 0;
  paper_tape_reader_input_gating i_dut (.*);
  tape_reader_model i_reader (.frame_in(go), .holes_in(holes), .sprocket_out(sprocket_amp_in), .channel_out(channel_amp_in));
  always #5 clk_in = ~clk_in;
  function automatic logic [5:0] rev(input logic [7:1] h);
    for (int i = 0; i < 6; i++)
      rev[i] = h[6 - i];
  endfunction
  task automatic conclude;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic axi(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    logic [2:0] hs;
    @(posedge clk_in);
    s_axi_awaddr_in <= a;
    s_axi_araddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= wr;
    s_axi_wvalid_in <= wr;
    s_axi_bready_in <= wr;
    s_axi_arvalid_in <= !wr;
    s_axi_rready_in <= !wr;
    for (n = 0; n < 40; n++)
    begin
      @(negedge clk_in);
      hs = {s_axi_awvalid_in & s_axi_awready_out, s_axi_wvalid_in & s_axi_wready_out, s_axi_arvalid_in & s_axi_arready_out};
      if ((s_axi_bready_in & s_axi_bvalid_out) | (s_axi_rready_in & s_axi_rvalid_out))
        break;
      @(posedge clk_in);
      if (hs[2]) s_axi_awvalid_in <= 1'b0;
      if (hs[1]) s_axi_wvalid_in <= 1'b0;
      if (hs[0]) s_axi_arvalid_in <= 1'b0;
    end
    rresp_q = wr ? s_axi_bresp_out : s_axi_rresp_out;
    rdata_q = s_axi_rdata_out;
    @(posedge clk_in);
    s_axi_bready_in <= 1'b0;
    s_axi_rready_in <= 1'b0;
    if (n == 40)
    begin
      failures++;
      conclude();
    end
  endtask
  // a clear first, so every scenario starts with the flag and error down
  task automatic setup(input logic [4:0] u, input logic dir, input logic skp);
    axi(1'b1, ADDR_CTRL, 32'h80 | 32'(skp) << CTRL_SKIPP_BIT);
    repeat (2) @(negedge clk_in);
    `CHK("clear", 1'b0, gated_feed_hole_out | pinch_roller_out)
    axi(1'b1, ADDR_CTRL, 32'(u) | 32'(dir) << CTRL_DIR_BIT | 32'(skp) << CTRL_SKIPP_BIT);
    sel_e = !dir && !fill_switch_in && u == (second_reader_in ? UNIT_READER2 : UNIT_READER1);
    {run_e, err_e, skip_e} = {2'b00, skp};
  endtask
  task automatic frame(input logic [7:1] h);
    logic c;
    c = sel_e & (|h | run_e);
    @(posedge clk_in);
    holes <= h;
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    repeat (6) @(posedge clk_in);
    @(negedge clk_in);
    `CHK("pinch", sel_e | tape_feed_switch_in, pinch_roller_out)
    `CHK("feed", sel_e, gated_feed_hole_out)
    `CHK("char", sel_e ? rev(h) : 6'h00, char_buffer_inputs_out)
    `CHK("parity", sel_e & h[7], odd_parity_flop_out)
    `CHK("inclk", c, input_clock_out)
    run_e = run_e | c;
    err_e = err_e | (c & !skip_e & !(^h));
    repeat (10) @(negedge clk_in);
    `CHK("running", run_e, transfer_running_out)
    `CHK("error", err_e, parity_error_out)
  endtask
  initial
  begin
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(negedge clk_in);
    `CHK("brake", 2'b10, {brake_drive_out, pinch_roller_out})
    axi(1'b1, ADDR_IRQ_MASK, 32'h2);
    setup(UNIT_READER1, 1'b0, 1'b0);
    frame(7'h00);
    frame(7'h01);
    frame(7'h00);
    `CHK("irq", 1'b1, irq_out)
    axi(1'b1, ADDR_IRQ_STAT, 32'h2);
    repeat (2) @(negedge clk_in);
    `CHK("irq clr", 1'b0, irq_out)
    axi(1'b0, ADDR_IRQ_STAT, 32'h0);
    `CHK("irq stat", 2'h1, rdata_q[1:0])
    axi(1'b0, ADDR_STATUS, 32'h0);
    `CHK("status", 2'b11, {rdata_q[4], rdata_q[0]})
    axi(1'b0, 12'h010, 32'h0);
    `CHK("unmapped", {AXI_SLVERR, 32'h0}, {rresp_q, rdata_q})
    setup(UNIT_READER1, 1'b0, 1'b1);
    repeat (8) frame(7'($random(seed)));
    setup(UNIT_READER1, 1'b1, 1'b0);
    frame(7'h7F);
    @(posedge clk_in);
    second_reader_in <= 1'b1;
    setup(UNIT_READER2, 1'b0, 1'b0);
    frame(7'h2A);
    setup(UNIT_READER1, 1'b0, 1'b0);
    frame(7'h2A);
    @(posedge clk_in);
    second_reader_in <= 1'b0;
    fill_switch_in <= 1'b1;
    setup(UNIT_READER1, 1'b0, 1'b0);
    frame(7'h15);
    @(posedge clk_in);
    fill_switch_in <= 1'b0;
    tape_feed_switch_in <= 1'b1;
    // fill released: the unit written above is addressed again
    sel_e = 1'b1;
    frame(7'h15);
    conclude();
  end
endmodule // paper_tape_reader_input_gating_tb
`default_nettype wire
